// ---- rtl/wdt_core.sv ----
// Watchdog timer with optional plain timer mode, one 8-bit control register.
// Assumes a special function register port on sys_clk: one-cycle write and
// read strobes with an 8-bit address; read data is registered.
`timescale 1ns/10ps
module wdt_core (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             sys_reset_req
);
   logic                     hit_wr;
   logic                     hit_rd;
   logic                     tick;
   logic [13:0]              load_val;
   logic                     restart;
   logic                     mode_wr;
   logic                     ovf;
   logic [3:0]               code_ff;
   logic [3:0]               nxt_code;
   logic                     mode_ff;
   logic                     nxt_mode;
   logic                     tmr_ovf_ff;
   logic                     nxt_tmr_ovf;
   logic                     expiry_ff;
   logic                     nxt_expiry;
   logic                     rbit_ff;
   logic                     nxt_rbit;
   logic [13:0]              cnt_ff;
   logic [13:0]              nxt_cnt;
   logic                     run_ff;
   logic                     nxt_run;
   wdt_pkg::wdt_restart_e    rst_st_ff;
   wdt_pkg::wdt_restart_e    nxt_rst_st;
   logic [13:0]              arm_val_ff;
   logic [13:0]              nxt_arm_val;
   logic [7:0]               rdata_ff;
   logic [7:0]               nxt_rdata;
   logic [2:0]               rst_cnt_ff;
   logic [2:0]               nxt_rst_cnt;
   logic                     sysrst_ff;
   logic                     nxt_sysrst;
   logic                     prev_b0_ff;
   logic                     nxt_prev_b0;

   // Address decode of the single control register
   assign hit_wr  = sfr_wr && (sfr_addr == wdt_pkg::CTRL_ADDR);
   assign hit_rd  = sfr_rd && (sfr_addr == wdt_pkg::CTRL_ADDR);
   assign mode_wr = hit_wr;

   // Prescaler cleared with the count so a restart gives a full first step
   wdt_prescaler #(
      .WIDTH (wdt_pkg::PRESCALE_W)
   ) u_pre (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clear   (restart || mode_wr),
      .tick    (tick)
   );

   // Table fed with the next code: a stale load would hit a back-to-back pair
   wdt_period_rom u_rom (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .code     (nxt_code),
      .load_val (load_val)
   );

   // Restart detection: a write with bit 0 low arms, the next write
   // with bit 0 high fires; a write with bit 0 low keeps it armed
   always_comb begin
      nxt_rst_st = rst_st_ff;
      restart    = 1'b0;
      case (rst_st_ff)
         wdt_pkg::WDT_RST_IDLE: begin
            if (hit_wr && !sfr_wdata[wdt_pkg::RESTART_BIT]) begin
               nxt_rst_st = wdt_pkg::WDT_RST_ARMED;
            end
         end
         wdt_pkg::WDT_RST_ARMED: begin
            if (hit_wr) begin
               if (sfr_wdata[wdt_pkg::RESTART_BIT]) begin
                  restart    = 1'b1;
                  nxt_rst_st = wdt_pkg::WDT_RST_IDLE;
               end else begin
                  nxt_rst_st = wdt_pkg::WDT_RST_ARMED;
               end
            end
         end
         default: nxt_rst_st = wdt_pkg::WDT_RST_IDLE;
      endcase
   end

   // Timeout when the count passes all-ones on a tick
   assign ovf = run_ff && tick && (&cnt_ff);

   // Control fields and flags; hardware set beats software clear
   always_comb begin
      nxt_code    = code_ff;
      nxt_mode    = mode_ff;
      nxt_rbit    = rbit_ff;
      nxt_tmr_ovf = tmr_ovf_ff;
      nxt_expiry  = expiry_ff;
      if (hit_wr) begin
         nxt_code = sfr_wdata[wdt_pkg::PERIOD_HI:wdt_pkg::PERIOD_LO];
         nxt_mode = sfr_wdata[wdt_pkg::MODE_BIT];
         nxt_rbit = sfr_wdata[wdt_pkg::RESTART_BIT];
         if (sfr_wdata[wdt_pkg::EXPIRY_BIT]) begin
            nxt_expiry = 1'b0;
         end
         if (sfr_wdata[wdt_pkg::TMR_OVF_BIT]) begin
            nxt_tmr_ovf = 1'b0;
         end
      end
      if (ovf && mode_ff) begin
         nxt_tmr_ovf = 1'b1;
      end
      if (ovf && !mode_ff) begin
         nxt_expiry = 1'b1;
      end
   end

   // Counter: loaded from the table on restart, from the latched period on mode write or overflow
   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_run     = run_ff;
      nxt_arm_val = load_val;
      if (restart) begin
         nxt_cnt = load_val;
         // Shortest code is not offered as a timer, so it stays stopped
         nxt_run = !(sfr_wdata[wdt_pkg::MODE_BIT] && (code_ff == wdt_pkg::CODE_SHORTEST));
      end else if (mode_wr) begin
         nxt_cnt = arm_val_ff;
         // Timer restarts counting only after the restart pair
         nxt_run = !sfr_wdata[wdt_pkg::MODE_BIT] && run_ff;
      end else if (ovf) begin
         nxt_cnt = arm_val_ff;
         nxt_run = !mode_ff;  // Timer is one-shot, watchdog keeps running
      end else if (run_ff && tick) begin
         nxt_cnt = cnt_ff + 14'h0001;
      end
      if (!restart) begin
         nxt_arm_val = arm_val_ff;
      end
   end

   // Processor reset pulse held a few cycles so it is not glitch sized
   always_comb begin
      nxt_rst_cnt = rst_cnt_ff;
      nxt_sysrst  = 1'b0;
      if (ovf && !mode_ff) begin
         nxt_rst_cnt = wdt_pkg::SYSRST_LEN;
      end else if (rst_cnt_ff != 3'h0) begin
         nxt_rst_cnt = rst_cnt_ff - 3'h1;
      end
      if (nxt_rst_cnt != 3'h0) begin
         nxt_sysrst = 1'b1;
      end
   end

   // Registered read data; bit 0 reads as stored, no action on read
   always_comb begin
      nxt_rdata = rdata_ff;
      if (hit_rd) begin
         nxt_rdata = {code_ff, tmr_ovf_ff, mode_ff, expiry_ff, rbit_ff};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_ff    <= 4'h0;
         mode_ff    <= 1'b0;
         rbit_ff    <= 1'b0;
         tmr_ovf_ff <= 1'b0;
         expiry_ff  <= 1'b0;
         cnt_ff     <= 14'h3FFF;
         run_ff     <= 1'b1;
         arm_val_ff <= 14'h3FFF;
         rst_st_ff  <= wdt_pkg::WDT_RST_IDLE;
         rdata_ff   <= wdt_pkg::CTRL_RESET;
         rst_cnt_ff <= 3'h0;
         sysrst_ff  <= 1'b0;
      end else begin
         code_ff    <= nxt_code;
         mode_ff    <= nxt_mode;
         rbit_ff    <= nxt_rbit;
         tmr_ovf_ff <= nxt_tmr_ovf;
         expiry_ff  <= nxt_expiry;
         cnt_ff     <= nxt_cnt;
         run_ff     <= nxt_run;
         arm_val_ff <= nxt_arm_val;
         rst_st_ff  <= nxt_rst_st;
         rdata_ff   <= nxt_rdata;
         rst_cnt_ff <= nxt_rst_cnt;
         sysrst_ff  <= nxt_sysrst;
      end
   end

   assign sfr_rdata     = rdata_ff;
   assign sys_reset_req = sysrst_ff;

   // Checker helper: bit 0 of the last control write, kept apart from the
   // restart state machine so the pair check does not lean on it
   always_comb begin
      nxt_prev_b0 = prev_b0_ff;
      if (hit_wr) begin
         nxt_prev_b0 = sfr_wdata[wdt_pkg::RESTART_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_b0_ff <= 1'b1;
      end else begin
         prev_b0_ff <= nxt_prev_b0;
      end
   end

   // Checks beside the logic
   a_wdog_reset_fires: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ovf && !mode_ff) |=> sys_reset_req [*4])
      else $error("Watchdog overflow did not reset processor");
   a_timer_no_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ovf && mode_ff && rst_cnt_ff == 3'h0) |=> !sys_reset_req)
      else $error("Timer mode overflow reset the processor");
   a_timer_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ovf && mode_ff) |=> tmr_ovf_ff)
      else $error("Timer flag not set on overflow");
   a_expiry_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ovf && !mode_ff) |=> expiry_ff)
      else $error("Expiry flag not set on overflow");
   a_expiry_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (hit_wr && sfr_wdata[wdt_pkg::EXPIRY_BIT] && !ovf) |=> !expiry_ff)
      else $error("Expiry flag not cleared by write");
   a_expiry_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (hit_wr && !sfr_wdata[wdt_pkg::EXPIRY_BIT] && expiry_ff) |=> expiry_ff)
      else $error("Writing zero cleared expiry flag");
   a_restart_pair: assert property (@(posedge sys_clk) disable iff (!rst_b)
      restart |-> hit_wr && sfr_wdata[wdt_pkg::RESTART_BIT] && !prev_b0_ff)
      else $error("Restart without clear-then-set pair");
   a_pair_restarts: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (hit_wr && sfr_wdata[wdt_pkg::RESTART_BIT] && !prev_b0_ff) |-> restart)
      else $error("Clear-then-set pair did not restart");
   a_restart_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
      restart |=> cnt_ff == $past(load_val))
      else $error("Restart did not load selected count");
   a_mode_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode_wr && !restart) |=> cnt_ff == $past(arm_val_ff))
      else $error("Mode write did not clear count");
   a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (run_ff && tick && !ovf && !hit_wr) |=> cnt_ff == $past(cnt_ff) + 14'h0001)
      else $error("Counter did not step on prescaler tick");

   c_wdog_reset: cover property (@(posedge sys_clk) disable iff (!rst_b) ovf && !mode_ff);
   c_timer_ovf: cover property (@(posedge sys_clk) disable iff (!rst_b) ovf && mode_ff);
   c_restart: cover property (@(posedge sys_clk) disable iff (!rst_b) restart);
   c_pair_back_to_back: cover property (@(posedge sys_clk) disable iff (!rst_b) hit_wr ##1 restart);
   c_expiry_cleared: cover property (@(posedge sys_clk) disable iff (!rst_b)
      hit_wr && sfr_wdata[wdt_pkg::EXPIRY_BIT] && expiry_ff);
endmodule

// ---- rtl/wdt_period_rom.sv ----
// Period code to counter load value table, registered output.
// Assumes the code input is the next value of the stored period code, so
// the registered output always matches the code currently stored.
`timescale 1ns/10ps
module wdt_period_rom (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  code,
   output logic      [13:0] load_val
);
   logic [13:0] val_ff;
   logic [13:0] nxt_val;

   // Load values per code
   always_comb begin
      case (code)
         4'h0:    nxt_val = 14'h3FFF;
         4'h1:    nxt_val = 14'h3FFE;
         4'h2:    nxt_val = 14'h3FFD;
         4'h3:    nxt_val = 14'h3FFB;
         4'h4:    nxt_val = 14'h3FF4;
         4'h5:    nxt_val = 14'h3FE8;
         4'h6:    nxt_val = 14'h3FCF;
         4'h7:    nxt_val = 14'h3F86;
         4'h8:    nxt_val = 14'h3F49;
         4'h9:    nxt_val = 14'h3F0C;
         4'hA:    nxt_val = 14'h3E9E;
         4'hB:    nxt_val = 14'h3B3B;
         4'hC:    nxt_val = 14'h38D9;
         4'hD:    nxt_val = 14'h3677;
         4'hE:    nxt_val = 14'h2364;
         default: nxt_val = 14'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         val_ff <= 14'h3FFF;
      end else begin
         val_ff <= nxt_val;
      end
   end

   assign load_val = val_ff;
endmodule

// ---- rtl/wdt_prescaler.sv ----
// Free-running prescaler that emits one-cycle tick pulses.
// Assumes its clear input comes from logic on the same clock.
`timescale 1ns/10ps
module wdt_prescaler #(
   parameter int WIDTH = 14
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic clear,
   output logic      tick
);
   logic [WIDTH-1:0] cnt_ff;
   logic [WIDTH-1:0] nxt_cnt;
   logic             tick_ff;
   logic             nxt_tick;

   // Wrap of the counter marks one prescaler overflow
   always_comb begin
      nxt_cnt  = clear ? '0 : cnt_ff + 1'b1;
      nxt_tick = !clear && (&cnt_ff);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule

// ---- shared/wdt_pkg.sv ----
// Package for the watchdog timer block: register layout, reset values,
// shortest period code and prescaler geometry.
// Assumes a single 250 MHz system clock; nothing is imported by users.
package wdt_pkg;
   localparam logic [7:0]  CTRL_ADDR     = 8'h91;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam int          PERIOD_HI     = 7;
   localparam int          PERIOD_LO     = 4;
   localparam int          TMR_OVF_BIT   = 3;
   localparam int          MODE_BIT      = 2;
   localparam int          EXPIRY_BIT    = 1;
   localparam int          RESTART_BIT   = 0;
   localparam int          PRESCALE_W    = 14;
   localparam int          COUNT_W       = 14;
   localparam logic [3:0]  CODE_SHORTEST = 4'h0;
   localparam int          SYSRST_CYCLES = 4;
   localparam logic [2:0]  SYSRST_LEN    = 3'h4;

   typedef enum logic [1:0] {
      WDT_RST_IDLE,
      WDT_RST_ARMED
   } wdt_restart_e;
endpackage

// ---- verification/wdt_bench.sv ----
// Self-checking bench for the watchdog control register and both timeout paths.
// Assumes wdt_core is the top module, reached only through its register strobes.
`timescale 1ns/10ps
module watchdog_timer_with_timer_mode_tb_top;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        sfr_wr = 1'b0;
   logic        sfr_rd = 1'b0;
   logic [7:0]  sfr_addr = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  sfr_rdata;
   logic        sys_reset_req;
   logic        req_d = 1'b0;
   logic [31:0] lfsr = 32'hC199;
   logic [7:0]  mdl_reg = 8'h00;    // Expected register image
   int          failures = 0;
   int          checks = 0;
   int          cyc = 0;
   int          rise_cyc = 0;
   int          rises = 0;
   int          width = 0;
   int          t0;
   int          r0;

   wdt_core i_dut (
      .sys_clk       (sys_clk),
      .rst_b         (rst_b),
      .sfr_wr        (sfr_wr),
      .sfr_rd        (sfr_rd),
      .sfr_addr      (sfr_addr),
      .sfr_wdata     (sfr_wdata),
      .sfr_rdata     (sfr_rdata),
      .sys_reset_req (sys_reset_req)
   );

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic results;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_reg(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_num(input int exp, input int got);
      checks++;
      if (got != exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // Write strobe for one cycle; the model follows only control writes
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      if (a == wdt_pkg::CTRL_ADDR) begin
         mdl_reg = {d[7:4], mdl_reg[3] & ~d[3], d[2], mdl_reg[1] & ~d[1], d[0]};
      end
   endtask

   // Back-to-back restart pair with no idle cycle between the two writes
   task automatic wr_pair(input logic [7:0] d0, input logic [7:0] d1);
      @(negedge sys_clk);
      sfr_wr = 1'b1;
      sfr_addr = wdt_pkg::CTRL_ADDR;
      sfr_wdata = d0;
      @(negedge sys_clk);
      sfr_wdata = d1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      mdl_reg = {d1[7:4], mdl_reg[3] & ~d0[3] & ~d1[3], d1[2], mdl_reg[1] & ~d0[1] & ~d1[1], d1[0]};
   endtask

   // Read data stands until the next read, so sampling a cycle late is safe
   task automatic rd_chk;
      @(negedge sys_clk);
      sfr_rd = 1'b1;
      sfr_addr = wdt_pkg::CTRL_ADDR;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      @(negedge sys_clk);
      cmp_reg(mdl_reg, sfr_rdata);
   endtask

   // Cycle count, reset request rise and pulse width; hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      req_d <= sys_reset_req;
      if (sys_reset_req === 1'b1 && req_d !== 1'b1) begin
         rise_cyc <= cyc;
         rises <= rises + 1;
         width <= 1;
      end else if (sys_reset_req === 1'b1) begin
         width <= width + 1;
      end
      if (cyc == 90000) begin
         failures++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      rd_chk();
      // Random fields, then a write elsewhere that must leave the register alone
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(wdt_pkg::CTRL_ADDR, {lfsr[7:4], 1'b0, lfsr[2], 2'b00});
         rd_chk();
         wr_reg({lfsr[23:17], 1'b0}, lfsr[15:8]);
         rd_chk();
      end
      // Watchdog mode, shortest code: one prescaler period to reset
      wr_reg(wdt_pkg::CTRL_ADDR, 8'h00);
      wr_reg(wdt_pkg::CTRL_ADDR, 8'h01);
      t0 = cyc;
      r0 = rises;
      for (int i = 0; i < 17000 && rises == r0; i++) begin
         @(negedge sys_clk);
      end
      cmp_num(r0 + 1, rises);
      cmp_num(1, int'(rise_cyc - t0 >= 16300 && rise_cyc - t0 <= 16500));
      repeat (8) @(negedge sys_clk);
      cmp_num(wdt_pkg::SYSRST_CYCLES, width);
      mdl_reg[1] = 1'b1;
      rd_chk();
      wr_reg(wdt_pkg::CTRL_ADDR, 8'h01);
      rd_chk();
      wr_reg(wdt_pkg::CTRL_ADDR, 8'h02);
      rd_chk();
      // Timer mode, code one: two prescaler periods, flag only
      wr_pair(8'h14, 8'h15);
      r0 = rises;
      repeat (32000) @(negedge sys_clk);
      rd_chk();
      repeat (1000) @(negedge sys_clk);
      mdl_reg[3] = 1'b1;
      rd_chk();
      cmp_num(r0, rises);
      results();
   end
endmodule
